// ===== adc_mode_pkg.sv
// Shared constants, types and register map for the ADC operating-mode controller
package adc_mode_pkg;

	// Register byte offsets on the APB slave
	localparam logic [11:0] OFS_MODE = 12'h000;
	localparam logic [11:0] OFS_CONFIG = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_DATA = 12'h00C;
	localparam logic [11:0] OFS_OFFSET_BASE = 12'h040;
	localparam logic [11:0] OFS_FULLSCALE_BASE = 12'h080;

	// Field positions
	localparam int MODE_LSB = 0;
	localparam int RATE_LSB = 4;
	localparam int XTAL_BIT = 16;
	localparam int CH_LSB = 0;
	localparam int CONT_READ_BIT = 8;
	localparam int BRIDGE_BIT = 9;

	// Reset values
	localparam logic [9:0] RATE_RESET = 10'h060;
	localparam logic [7:0] CH_RESET = 8'h01;
	localparam logic [23:0] OFFSET_RESET = 24'h800000;
	localparam logic [23:0] FULLSCALE_RESET = 24'h500000;

	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int MOD_DIV = 8;
	localparam int DEC_RATIO = 1024;
	localparam int SETTLE_CONV = 4;
	localparam int PWRUP_NS = 1000000;
	localparam int PWRUP_CYC = PWRUP_NS / CLK_PERIOD_NS;
	localparam int RESULT_BITS = 24;

	typedef enum logic [2:0] {
		MODE_CONT = 3'b000,
		MODE_SINGLE = 3'b001,
		MODE_IDLE = 3'b010,
		MODE_PDOWN = 3'b011,
		MODE_INT_ZERO = 3'b100,
		MODE_INT_FULL = 3'b101,
		MODE_SYS_ZERO = 3'b110,
		MODE_SYS_FULL = 3'b111
	} mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PDOWN = 2'b01,
		ST_WAKE = 2'b10,
		ST_RUN = 2'b11
	} state_t;

	// Controls toward the analog front end and clocking
	typedef struct packed {
		logic mod_reset;
		logic analog_pd;
		logic xtal_en;
		logic bridge_sw;
		logic input_short;
		logic fullscale_ref;
		logic [7:0] chan_sel;
	} afe_ctl_t;

endpackage

// ===== adc_mode_ctrl.sv
// Operating-mode controller of a sigma-delta ADC with APB registers and serial result port
//
// Overview of operation
// - Mode 000 (reset default) converts continuously, each result into data register.
// - Each completed conversion drives shared data-out/ready pin and ready flag low.
// - Host sets continuous read enable to stream conversion results.
// - In continuous read, result shifts out on data line with host serial clocks.
// - After reset or reconfiguration, first result waits full filter settling time.
// - Later continuous results come at programmed output data rate.
// - Mode 001 powers up and performs exactly one settled conversion.
// - Single conversion first waits up to 1 ms for clock power-up.
// - After single conversion: store result, ready low, return to power-down.
// - Single result stays in data register until another conversion overwrites it.
// - Ready stays low until the result is read or shifted out, or a calibration mode is written.
// - Mode 010 holds filter and modulator in reset, modulator clocks running.
// - Mode 011 powers everything down except the bridge power-down switch and a selected crystal.
// - In power-down the crystal oscillator keeps running when selected.
// - Mode 100 shorts the input internally and measures zero-scale offset.
// - Mode 101 applies internal full-scale voltage and measures gain coefficient.
// - Calibration drives ready high at start, low at completion.
// - Any completed calibration switches the device into idle mode.
// - Zero-scale calibration writes offset register of the selected channel.
// - Full-scale calibration writes full-scale register of the selected channel.
// - Output rate is modulator clock divided by 1024 times filter word 1..1023.
module adc_mode_ctrl #(
	parameter int PWRUP_CYCLES = adc_mode_pkg::PWRUP_CYC,
	parameter int MOD_DIV = adc_mode_pkg::MOD_DIV,
	parameter int SETTLE_CONV = adc_mode_pkg::SETTLE_CONV
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Filter output from the modulator datapath
	input wire logic [23:0] conv_data_i,
	// Serial result pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	output logic dout_rdy_o,
	// Analog front end controls
	output adc_mode_pkg::afe_ctl_t afe_o
);

	localparam int RB = adc_mode_pkg::RESULT_BITS;

	function automatic logic [2:0] chan_index(input logic [7:0] sel);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (sel[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic addr_mapped(input logic [11:0] a);
		logic hit;
		hit = (a == adc_mode_pkg::OFS_MODE) || (a == adc_mode_pkg::OFS_CONFIG) ||
			(a == adc_mode_pkg::OFS_STATUS) || (a == adc_mode_pkg::OFS_DATA);
		if (a[1:0] == 2'h0 && (a[11:5] == adc_mode_pkg::OFS_OFFSET_BASE[11:5] ||
			a[11:5] == adc_mode_pkg::OFS_FULLSCALE_BASE[11:5])) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// Bus decode
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic mode_wr;
	logic cfg_wr;
	logic data_rd;
	assign acc = psel_i && penable_i;
	assign wr_acc = acc && pwrite_i && addr_mapped(paddr_i);
	assign rd_acc = acc && !pwrite_i;
	assign mode_wr = wr_acc && paddr_i == adc_mode_pkg::OFS_MODE;
	assign cfg_wr = wr_acc && paddr_i == adc_mode_pkg::OFS_CONFIG;
	assign data_rd = rd_acc && paddr_i == adc_mode_pkg::OFS_DATA;
	assign pready_o = 1'b1;
	assign pslverr_o = acc && !addr_mapped(paddr_i);

	// Pin synchronisers
	logic [2:0] sclk_sync_r;
	logic [2:0] csn_sync_r;
	logic sclk_fall;
	logic cs_fall;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_sync_r <= 3'h7;
			csn_sync_r <= 3'h7;
		end else begin
			sclk_sync_r <= {sclk_sync_r[1:0], sclk_i};
			csn_sync_r <= {csn_sync_r[1:0], cs_n_i};
		end
	end
	assign sclk_fall = sclk_sync_r[2] && !sclk_sync_r[1];
	assign cs_fall = csn_sync_r[2] && !csn_sync_r[1];

	// Control registers
	adc_mode_pkg::mode_t mode_r, mode_nxt;
	logic [9:0] rate_r, rate_nxt;
	logic xtal_r, xtal_nxt;
	logic [7:0] chsel_r, chsel_nxt;
	logic cont_rd_r, cont_rd_nxt;
	logic bridge_r, bridge_nxt;

	// Sequencer state
	adc_mode_pkg::state_t state_r, state_nxt;
	logic [3:0] div_r, div_nxt;
	logic [19:0] cyc_r, cyc_nxt;
	logic [7:0] settle_r, settle_nxt;
	logic [15:0] wake_r, wake_nxt;
	logic [23:0] data_r, data_nxt;
	logic ready_n_r, ready_n_nxt;
	logic [23:0] ofs_r [8];
	logic [23:0] ofs_nxt [8];
	logic [23:0] gain_r [8];
	logic [23:0] gain_nxt [8];

	// Serial shifter
	logic [23:0] shift_r, shift_nxt;
	logic [4:0] bit_r, bit_nxt;
	logic shifting_r, shifting_nxt;
	logic dout_r, dout_nxt;
	logic [31:0] prdata_r, prdata_nxt;

	logic mod_tick;
	logic conv_done;
	logic shift_end;
	logic [9:0] rate_eff;
	logic [19:0] conv_len;
	logic [2:0] ch;
	logic [7:0] settle_last;
	assign rate_eff = (rate_r == 10'h000) ? 10'h001 : rate_r;
	assign conv_len = {rate_eff, 10'h000};
	assign mod_tick = (div_r == 4'(MOD_DIV - 1)) && state_r != adc_mode_pkg::ST_PDOWN;
	assign conv_done = state_r == adc_mode_pkg::ST_RUN && mod_tick &&
		cyc_r == conv_len - 20'h00001;
	assign ch = chan_index(chsel_r);
	assign settle_last = 8'(SETTLE_CONV - 1);
	assign shift_end = shifting_r && sclk_fall && bit_r == 5'(RB - 1);

	always_comb begin
		mode_nxt = mode_r;
		rate_nxt = rate_r;
		xtal_nxt = xtal_r;
		chsel_nxt = chsel_r;
		cont_rd_nxt = cont_rd_r;
		bridge_nxt = bridge_r;
		state_nxt = state_r;
		div_nxt = mod_tick || state_r == adc_mode_pkg::ST_PDOWN ? 4'h0 : div_r + 4'h1;
		cyc_nxt = cyc_r;
		settle_nxt = settle_r;
		wake_nxt = wake_r;
		data_nxt = data_r;
		ready_n_nxt = ready_n_r;
		for (int i = 0; i < 8; i++) begin
			ofs_nxt[i] = ofs_r[i];
			gain_nxt[i] = gain_r[i];
		end
		// Software writes to coefficients; a calibration result below overrides them
		if (wr_acc && paddr_i[11:5] == adc_mode_pkg::OFS_OFFSET_BASE[11:5]) begin
			ofs_nxt[paddr_i[4:2]] = pwdata_i[23:0];
		end
		if (wr_acc && paddr_i[11:5] == adc_mode_pkg::OFS_FULLSCALE_BASE[11:5]) begin
			gain_nxt[paddr_i[4:2]] = pwdata_i[23:0];
		end
		// Reading the result releases the ready flag; a completing conversion wins below
		if (data_rd || shift_end) begin
			ready_n_nxt = 1'b1;
		end
		if (cfg_wr) begin
			chsel_nxt = pwdata_i[adc_mode_pkg::CH_LSB +: 8];
			cont_rd_nxt = pwdata_i[adc_mode_pkg::CONT_READ_BIT];
			bridge_nxt = pwdata_i[adc_mode_pkg::BRIDGE_BIT];
			cyc_nxt = 20'h00000;
			settle_nxt = 8'h00;
		end
		case (state_r)
			adc_mode_pkg::ST_WAKE: begin
				wake_nxt = wake_r + 16'h0001;
				if (wake_r == 16'(PWRUP_CYCLES - 1)) begin
					state_nxt = adc_mode_pkg::ST_RUN;
					cyc_nxt = 20'h00000;
					settle_nxt = 8'h00;
				end
			end
			adc_mode_pkg::ST_RUN: begin
				if (mod_tick && !cfg_wr) begin
					cyc_nxt = conv_done ? 20'h00000 : cyc_r + 20'h00001;
				end
				if (conv_done && !cfg_wr) begin
					if (settle_r != settle_last) begin
						settle_nxt = settle_r + 8'h01;
					end else begin
						case (mode_r)
							adc_mode_pkg::MODE_CONT: begin
								data_nxt = conv_data_i;
								ready_n_nxt = 1'b0;
							end
							adc_mode_pkg::MODE_SINGLE: begin
								data_nxt = conv_data_i;
								ready_n_nxt = 1'b0;
								mode_nxt = adc_mode_pkg::MODE_PDOWN;
								state_nxt = adc_mode_pkg::ST_PDOWN;
							end
							adc_mode_pkg::MODE_INT_ZERO, adc_mode_pkg::MODE_SYS_ZERO: begin
								ofs_nxt[ch] = conv_data_i;
								ready_n_nxt = 1'b0;
								mode_nxt = adc_mode_pkg::MODE_IDLE;
								state_nxt = adc_mode_pkg::ST_IDLE;
							end
							adc_mode_pkg::MODE_INT_FULL, adc_mode_pkg::MODE_SYS_FULL: begin
								gain_nxt[ch] = conv_data_i;
								ready_n_nxt = 1'b0;
								mode_nxt = adc_mode_pkg::MODE_IDLE;
								state_nxt = adc_mode_pkg::ST_IDLE;
							end
							default: begin
								state_nxt = adc_mode_pkg::ST_IDLE;
							end
						endcase
					end
				end
			end
			default: begin
			end
		endcase
		// A new mode restarts from scratch, whatever was in progress
		if (mode_wr) begin
			mode_nxt = adc_mode_pkg::mode_t'(pwdata_i[adc_mode_pkg::MODE_LSB +: 3]);
			rate_nxt = pwdata_i[adc_mode_pkg::RATE_LSB +: 10];
			xtal_nxt = pwdata_i[adc_mode_pkg::XTAL_BIT];
			cyc_nxt = 20'h00000;
			settle_nxt = 8'h00;
			wake_nxt = 16'h0000;
			case (mode_nxt)
				adc_mode_pkg::MODE_CONT: state_nxt = adc_mode_pkg::ST_RUN;
				adc_mode_pkg::MODE_SINGLE: state_nxt = adc_mode_pkg::ST_WAKE;
				adc_mode_pkg::MODE_IDLE: state_nxt = adc_mode_pkg::ST_IDLE;
				adc_mode_pkg::MODE_PDOWN: state_nxt = adc_mode_pkg::ST_PDOWN;
				default: begin
					state_nxt = adc_mode_pkg::ST_RUN;
					ready_n_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r <= adc_mode_pkg::MODE_CONT;
			rate_r <= adc_mode_pkg::RATE_RESET;
			xtal_r <= 1'b0;
			chsel_r <= adc_mode_pkg::CH_RESET;
			cont_rd_r <= 1'b0;
			bridge_r <= 1'b0;
			state_r <= adc_mode_pkg::ST_RUN;
			div_r <= 4'h0;
			cyc_r <= 20'h00000;
			settle_r <= 8'h00;
			wake_r <= 16'h0000;
			data_r <= 24'h000000;
			ready_n_r <= 1'b1;
			for (int i = 0; i < 8; i++) begin
				ofs_r[i] <= adc_mode_pkg::OFFSET_RESET;
				gain_r[i] <= adc_mode_pkg::FULLSCALE_RESET;
			end
		end else begin
			mode_r <= mode_nxt;
			rate_r <= rate_nxt;
			xtal_r <= xtal_nxt;
			chsel_r <= chsel_nxt;
			cont_rd_r <= cont_rd_nxt;
			bridge_r <= bridge_nxt;
			state_r <= state_nxt;
			div_r <= div_nxt;
			cyc_r <= cyc_nxt;
			settle_r <= settle_nxt;
			wake_r <= wake_nxt;
			data_r <= data_nxt;
			ready_n_r <= ready_n_nxt;
			for (int i = 0; i < 8; i++) begin
				ofs_r[i] <= ofs_nxt[i];
				gain_r[i] <= gain_nxt[i];
			end
		end
	end

	// Serial result port: while idle the data line shows the ready flag
	always_comb begin
		shift_nxt = shift_r;
		bit_nxt = bit_r;
		shifting_nxt = shifting_r;
		if (!shifting_r && cont_rd_r && !ready_n_r && cs_fall) begin
			shift_nxt = data_r;
			bit_nxt = 5'h00;
			shifting_nxt = 1'b1;
		end else if (shifting_r && csn_sync_r[2]) begin
			shifting_nxt = 1'b0;
		end else if (shifting_r && sclk_fall) begin
			shift_nxt = {shift_r[22:0], 1'b0};
			bit_nxt = bit_r + 5'h01;
			shifting_nxt = !shift_end;
		end
		dout_nxt = shifting_nxt ? shift_nxt[23] : ready_n_nxt;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift_r <= 24'h000000;
			bit_r <= 5'h00;
			shifting_r <= 1'b0;
			dout_r <= 1'b1;
		end else begin
			shift_r <= shift_nxt;
			bit_r <= bit_nxt;
			shifting_r <= shifting_nxt;
			dout_r <= dout_nxt;
		end
	end

	// Read data is captured in the setup phase so prdata comes straight from a flop
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel_i && !penable_i && !pwrite_i) begin
			prdata_nxt = 32'h00000000;
			if (paddr_i == adc_mode_pkg::OFS_MODE) begin
				prdata_nxt[adc_mode_pkg::MODE_LSB +: 3] = mode_r;
				prdata_nxt[adc_mode_pkg::RATE_LSB +: 10] = rate_r;
				prdata_nxt[adc_mode_pkg::XTAL_BIT] = xtal_r;
			end else if (paddr_i == adc_mode_pkg::OFS_CONFIG) begin
				prdata_nxt[adc_mode_pkg::CH_LSB +: 8] = chsel_r;
				prdata_nxt[adc_mode_pkg::CONT_READ_BIT] = cont_rd_r;
				prdata_nxt[adc_mode_pkg::BRIDGE_BIT] = bridge_r;
			end else if (paddr_i == adc_mode_pkg::OFS_STATUS) begin
				prdata_nxt[7:0] = {1'b0, state_r, 1'b0, ch, ready_n_r};
			end else if (paddr_i == adc_mode_pkg::OFS_DATA) begin
				prdata_nxt[23:0] = data_r;
			end else if (paddr_i[11:5] == adc_mode_pkg::OFS_OFFSET_BASE[11:5]) begin
				prdata_nxt[23:0] = ofs_r[paddr_i[4:2]];
			end else if (paddr_i[11:5] == adc_mode_pkg::OFS_FULLSCALE_BASE[11:5]) begin
				prdata_nxt[23:0] = gain_r[paddr_i[4:2]];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_r <= 32'h00000000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata_o = prdata_r;
	assign dout_rdy_o = dout_r;

	// Analog controls; bridge switch and a selected crystal survive power-down
	always_comb begin
		afe_o.mod_reset = state_r != adc_mode_pkg::ST_RUN;
		afe_o.analog_pd = state_r == adc_mode_pkg::ST_PDOWN;
		afe_o.xtal_en = xtal_r;
		afe_o.bridge_sw = bridge_r;
		afe_o.input_short = state_r == adc_mode_pkg::ST_RUN &&
			mode_r == adc_mode_pkg::MODE_INT_ZERO;
		afe_o.fullscale_ref = state_r == adc_mode_pkg::ST_RUN &&
			mode_r == adc_mode_pkg::MODE_INT_FULL;
		afe_o.chan_sel = chsel_r;
	end

endmodule

// ===== host_serial.sv
// Host side of the serial result port: frames one 24-bit word
module host_serial (
	input wire logic clk_i,
	input wire logic dout_i,
	output logic sclk_o,
	output logic cs_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock idles high and stands still between frames
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
	end
	task automatic read_word(output logic [23:0] w, output logic rdy);
		@(posedge clk_i) cs_n_o <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			// Sample well after the pin has moved, then clock the next bit
			repeat (8) @(posedge clk_i);
			w[i] = dout_i;
			sclk_o <= 1'b0;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
		end
		repeat (8) @(posedge clk_i);
		rdy = dout_i;
		cs_n_o <= 1'b1;
	endtask
endmodule

// ===== adc_mode_ctrl_asserts.sv
// Port-level checks of the ADC operating-mode controller
module adc_mode_ctrl_asserts #(
	parameter int PWRUP_CYCLES = adc_mode_pkg::PWRUP_CYC,
	parameter int MOD_DIV = adc_mode_pkg::MOD_DIV,
	parameter int SETTLE_CONV = adc_mode_pkg::SETTLE_CONV
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [23:0] conv_data_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic dout_rdy_o,
	input wire adc_mode_pkg::afe_ctl_t afe_o
);
	logic wr_mode;
	logic wr_cfg;
	logic [2:0] mode_r;
	logic xtal_r;
	logic [9:0] cfg_r;
	assign wr_mode = psel_i && penable_i && pwrite_i && paddr_i == adc_mode_pkg::OFS_MODE;
	assign wr_cfg = psel_i && penable_i && pwrite_i && paddr_i == adc_mode_pkg::OFS_CONFIG;
	// Shadow of what software last wrote; internal mode changes are not seen
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r <= 3'h0;
			xtal_r <= 1'b0;
			cfg_r <= 10'h001;
		end else begin
			if (wr_mode) begin
				mode_r <= pwdata_i[2:0];
				xtal_r <= pwdata_i[16];
			end
			if (wr_cfg) begin
				cfg_r <= pwdata_i[9:0];
			end
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_idle_holds_reset: assert property (mode_r == 3'h2 && !wr_mode |=> afe_o.mod_reset)
		else $error("idle mode without modulator reset");
	a_pdown_keeps_bridge: assert property (mode_r == 3'h3 && !wr_mode
		|=> afe_o.analog_pd && afe_o.bridge_sw == cfg_r[9])
		else $error("power-down state of front end wrong");
	a_xtal_kept: assert property (afe_o.xtal_en == xtal_r)
		else $error("crystal enable differs from select");
	a_chan_follows: assert property (afe_o.chan_sel == cfg_r[7:0])
		else $error("channel select differs from config");
	a_cal_rdy_high: assert property (wr_mode && pwdata_i[2] && cs_n_i |=> ##[0:2] dout_rdy_o)
		else $error("ready not raised at calibration start");
	a_no_early_result: assert property (wr_mode && cs_n_i |=> !$fell(dout_rdy_o) [*8])
		else $error("result reported before settling");
	a_int_zero_short: assert property (wr_mode && pwdata_i[2:0] == 3'h4
		|=> ##[0:2] afe_o.input_short)
		else $error("internal short not applied");
	a_int_full_ref: assert property (wr_mode && pwdata_i[2:0] == 3'h5
		|=> ##[0:2] afe_o.fullscale_ref)
		else $error("full-scale reference not applied");
	a_cal_exclusive: assert property (afe_o.input_short |-> !afe_o.fullscale_ref && !afe_o.mod_reset)
		else $error("short with reference or reset");
	cover property (wr_mode && pwdata_i[2]);
	cover property ($fell(dout_rdy_o));
	cover property (afe_o.analog_pd && afe_o.bridge_sw);
endmodule

// ===== adc_operating_mode_control_test.sv
// Self-checking bench of the ADC operating-mode controller
module adc_operating_mode_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] MO = adc_mode_pkg::OFS_MODE;
	localparam logic [11:0] DA = adc_mode_pkg::OFS_DATA;
	localparam int CONV = 1024 * 2;
	logic clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, sclk, cs_n, dout_rdy, rdy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] conv, w;
	adc_mode_pkg::afe_ctl_t afe;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int t0;
	adc_mode_ctrl #(.PWRUP_CYCLES(20), .MOD_DIV(2), .SETTLE_CONV(1)) i_adc_mode_ctrl (
		.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .conv_data_i(conv), .sclk_i(sclk),
		.cs_n_i(cs_n), .dout_rdy_o(dout_rdy), .afe_o(afe));
	host_serial i_host_serial (.clk_i(clk_i), .dout_i(dout_rdy), .sclk_o(sclk), .cs_n_o(cs_n));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) begin
			k++;
			if (k > 50) begin
				n_errors++;
				give_verdict();
			end
			@(posedge clk_i);
		end
		rd = prdata;
		rdy = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task automatic wait_rdy;
		int k;
		k = 0;
		while (dout_rdy !== 1'b0) begin
			@(posedge clk_i);
			k++;
			if (k > 5000) begin
				n_errors++;
				$display("MISMATCH ready expected 0 seen timeout");
				give_verdict();
			end
		end
	endtask
	task automatic t_reset;
		rdc(MO, 32'h00000600, "mode");
		rdc(adc_mode_pkg::OFS_CONFIG, 32'h00000001, "config");
		rdc(12'h048, 32'h00800000, "offset2");
		rdc(12'h088, 32'h00500000, "fullscale2");
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", {31'h0, rdy}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_cont;
		conv <= 24'hA5C3E1;
		apb(1'b1, MO, 32'h00000010);
		t0 = cyc;
		wait_rdy();
		chk("settle", {31'h0, cyc - t0 >= CONV - 4 && cyc - t0 <= CONV + 6}, 32'h1);
		t0 = cyc;
		rdc(DA, 32'h00A5C3E1, "data");
		repeat (3) @(posedge clk_i);
		chk("ready after read", {31'h0, dout_rdy}, 32'h1);
		conv <= 24'h3C5A96;
		wait_rdy();
		chk("rate", cyc - t0, CONV);
		rdc(DA, 32'h003C5A96, "data2");
		$display("test continuous done");
	endtask
	task automatic t_continuous_read_enable;
		conv <= 24'h5AA5C3;
		apb(1'b1, adc_mode_pkg::OFS_CONFIG, 32'h00000101);
		wait_rdy();
		i_host_serial.read_word(w, rdy);
		chk("serial word", {8'h0, w}, 32'h005AA5C3);
		chk("pin after frame", {31'h0, rdy}, 32'h1);
		apb(1'b1, adc_mode_pkg::OFS_CONFIG, 32'h00000004);
		$display("test continuous read done");
	endtask
	task automatic t_single;
		conv <= 24'h123456;
		apb(1'b1, MO, 32'h00000011);
		t0 = cyc;
		wait_rdy();
		chk("wake", {31'h0, cyc - t0 >= CONV + 16 && cyc - t0 <= CONV + 30}, 32'h1);
		conv <= 24'h654321;
		repeat (CONV + 50) @(posedge clk_i);
		chk("ready held", {31'h0, dout_rdy}, 32'h0);
		chk("powered down", {31'h0, afe.analog_pd}, 32'h1);
		rdc(MO, 32'h00000013, "mode pdown");
		rdc(DA, 32'h00123456, "single data");
		$display("test single done");
	endtask
	task automatic t_cal;
		for (int m = 4; m < 8; m++) begin
			conv <= 24'h100000 + 24'(m);
			apb(1'b1, MO, 32'h00000010 | 32'(m));
			repeat (3) @(posedge clk_i);
			chk("cal ready", {31'h0, dout_rdy}, 32'h1);
			chk("short", {31'h0, afe.input_short}, {31'h0, m == 4});
			chk("fullscale ref", {31'h0, afe.fullscale_ref}, {31'h0, m == 5});
			wait_rdy();
			chk("idle reset", {31'h0, afe.mod_reset}, 32'h1);
			rdc(MO, 32'h00000012, "cal to idle");
			rdc(m[0] ? 12'h088 : 12'h048, 32'h00100000 + 32'(m), "coef");
		end
		$display("test calibration done");
	endtask
	task automatic t_abort;
		apb(1'b1, MO, 32'h00000014);
		repeat (1000) @(posedge clk_i);
		apb(1'b1, MO, 32'h00000012);
		repeat (CONV + 50) @(posedge clk_i);
		chk("abort ready", {31'h0, dout_rdy}, 32'h1);
		rdc(12'h048, 32'h00100006, "abort coef");
		apb(1'b1, adc_mode_pkg::OFS_CONFIG, 32'h00000204);
		apb(1'b1, MO, 32'h00010013);
		repeat (4) @(posedge clk_i);
		chk("pd bridge", {29'h0, afe.analog_pd, afe.bridge_sw, afe.xtal_en}, 32'h7);
		$display("test abort and power-down done");
	endtask
	initial begin
		rstn_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		conv = 24'h000000;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_cont();
		t_continuous_read_enable();
		t_single();
		t_cal();
		t_abort();
		give_verdict();
	end
endmodule
bind adc_mode_ctrl adc_mode_ctrl_asserts #(
	.PWRUP_CYCLES(PWRUP_CYCLES), .MOD_DIV(MOD_DIV), .SETTLE_CONV(SETTLE_CONV)
) i_asserts (
	.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .conv_data_i(conv_data_i),
	.sclk_i(sclk_i), .cs_n_i(cs_n_i), .dout_rdy_o(dout_rdy_o), .afe_o(afe_o));
